// [rtl/sctc_pkg.sv]
// Purpose: Shared constants and types for the split capture timer control block
// Assumes: Byte-wide special function register bus, one clock
// Notes:   Field positions follow the control register layout, high flag at the top
package sctc_pkg;
	localparam logic [7:0] ADDR_CTRL       = 8'hc8;
	localparam logic [7:0] ADDR_RELOAD_LO  = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HI  = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LO   = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HI   = 8'hcd;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic [7:0] BYTE_ALL_ONES   = 8'hff;
	localparam logic [7:0] BYTE_ONE        = 8'h01;

	typedef struct packed {
		logic high_event_flag;
		logic low_event_flag;
		logic low_irq_enable;
		logic split_select;
		logic high_capture_enable;
		logic low_capture_enable;
		logic high_run_enable;
		logic low_run_enable;
	} sctc_ctrl_t;

	localparam sctc_ctrl_t CTRL_RESET = sctc_ctrl_t'(8'h00);

	// Per-cycle hardware events that set flags or load bytes
	typedef struct packed {
		logic set_high;
		logic set_low;
		logic cap_low;
		logic cap_high;
	} sctc_evt_t;
endpackage : sctc_pkg

// [rtl/sctc_timer.sv]
// Purpose: Control, flags and capture/reload bytes of a 16-bit or split 8-bit timer
// Assumes: Tick enables come from an external clock selector on the same clock
// Notes:   Capture pin is asynchronous and passes two flip-flops first
//
// Contract
// RQ1: High flag on high overflow or capture
// RQ2: Hardware never clears high flag itself
// RQ3: Low flag on low overflow or capture
// RQ4: Low flag on low byte roll in wide
// RQ5: Wide capture: high flag capture, low overflow
// RQ6: Irq is high flag or enabled low
// RQ7: Split select picks wide or two halves
// RQ8: High capture enable only in split
// RQ9: Low capture enable selects capture mode
// RQ10: High run enables high half in split
// RQ11: Low run enables low or whole timer
// RQ12: Reload byte writes take effect immediately
// RQ13: Low byte holds capture or reload value
// RQ14: Wide overflow reloads and sets high flag
// RQ15: Wide capture copies counter into reload pair
// RQ16: Capture works even when run is off
// RQ17: Capture edge is rising, falling or both
// RQ18: Write zero clears flag, set wins
module sctc_timer (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       low_tick,
	input  wire logic       high_tick,
	input  wire logic       cap_pin,
	input  wire logic       cap_rise_en,
	input  wire logic       cap_fall_en,
	output logic            timer_irq
);
	sctc_pkg::sctc_ctrl_t ctrl_r;
	sctc_pkg::sctc_ctrl_t ctrl_nxt;
	sctc_pkg::sctc_evt_t  evt;
	logic [7:0] reload_lo_r;
	logic [7:0] reload_hi_r;
	logic [7:0] count_lo_r;
	logic [7:0] count_hi_r;
	logic [7:0] reload_lo_nxt;
	logic [7:0] reload_hi_nxt;
	logic [7:0] count_lo_nxt;
	logic [7:0] count_hi_nxt;
	logic [7:0] sfr_rdata_r;
	logic       timer_irq_r;
	logic       pin_meta_r;
	logic       pin_sync_r;
	logic       pin_prev_r;

	// Edge detector reads only the second stage and its delayed copy
	wire cap_event = (cap_rise_en & pin_sync_r & ~pin_prev_r) |
		(cap_fall_en & ~pin_sync_r & pin_prev_r); // RQ17

	wire wide      = ~ctrl_r.split_select; // RQ7
	wire lo_cap    = ctrl_r.low_capture_enable; // RQ9
	wire hi_cap    = ctrl_r.split_select & ctrl_r.high_capture_enable; // RQ8
	wire lo_step   = ctrl_r.low_run_enable & low_tick; // RQ11
	wire hi_step   = ~wide & ctrl_r.high_run_enable & high_tick; // RQ10
	wire lo_roll   = lo_step & (count_lo_r == sctc_pkg::BYTE_ALL_ONES);
	wire hi_roll_s = hi_step & (count_hi_r == sctc_pkg::BYTE_ALL_ONES);
	wire full_roll = wide & lo_roll & (count_hi_r == sctc_pkg::BYTE_ALL_ONES);

	wire wr_ctrl   = sfr_wr & (sfr_addr == sctc_pkg::ADDR_CTRL);
	wire wr_rl     = sfr_wr & (sfr_addr == sctc_pkg::ADDR_RELOAD_LO);
	wire wr_rh     = sfr_wr & (sfr_addr == sctc_pkg::ADDR_RELOAD_HI);
	wire wr_cl     = sfr_wr & (sfr_addr == sctc_pkg::ADDR_COUNT_LO);
	wire wr_ch     = sfr_wr & (sfr_addr == sctc_pkg::ADDR_COUNT_HI);

	wire [7:0] lo_inc = count_lo_r + sctc_pkg::BYTE_ONE;
	wire [7:0] hi_inc = count_hi_r + sctc_pkg::BYTE_ONE;
	wire [7:0] ctrl_wbits = sfr_wdata;

	// Flag set sources per mode
	assign evt.cap_low  = cap_event & lo_cap; // RQ16
	assign evt.cap_high = cap_event & (wide ? lo_cap : hi_cap); // RQ15
	assign evt.set_high = (wide & ~lo_cap & full_roll) | // RQ14
		(~wide & ~hi_cap & hi_roll_s) | // RQ1
		evt.cap_high; // RQ5
	assign evt.set_low  = (wide & ~lo_cap & lo_roll) | // RQ4
		(wide & lo_cap & full_roll) | // RQ5
		(~wide & ~lo_cap & lo_roll) | // RQ3
		(~wide & evt.cap_low); // RQ3

	// Hardware only ever sets flags; software write value is the only clear path
	always_comb begin // RQ2
		ctrl_nxt = wr_ctrl ? sctc_pkg::sctc_ctrl_t'(ctrl_wbits) : ctrl_r;
		ctrl_nxt.high_event_flag = ctrl_nxt.high_event_flag | evt.set_high; // RQ18
		ctrl_nxt.low_event_flag  = ctrl_nxt.low_event_flag | evt.set_low; // RQ18
	end

	// Capture beats a same-cycle software write; writes land at once otherwise
	assign reload_lo_nxt = evt.cap_low ? count_lo_r : (wr_rl ? sfr_wdata : reload_lo_r); // RQ13
	assign reload_hi_nxt = evt.cap_high ? count_hi_r : (wr_rh ? sfr_wdata : reload_hi_r); // RQ12

	// Timer mode reloads on wrap; capture mode runs free through it
	always_comb begin
		count_lo_nxt = count_lo_r;
		count_hi_nxt = count_hi_r;
		if (wide) begin
			if (full_roll) begin
				count_lo_nxt = lo_cap ? lo_inc : reload_lo_r; // RQ14
				count_hi_nxt = lo_cap ? hi_inc : reload_hi_r; // RQ14
			end else if (lo_step) begin
				count_lo_nxt = lo_inc;
				count_hi_nxt = lo_roll ? hi_inc : count_hi_r;
			end
		end else begin
			if (lo_step) begin
				count_lo_nxt = (lo_roll & ~lo_cap) ? reload_lo_r : lo_inc;
			end
			if (hi_step) begin
				count_hi_nxt = (hi_roll_s & ~hi_cap) ? reload_hi_r : hi_inc;
			end
		end
		if (wr_cl) begin
			count_lo_nxt = sfr_wdata;
		end
		if (wr_ch) begin
			count_hi_nxt = sfr_wdata;
		end
	end

	logic [7:0] rd_mux;
	always_comb begin
		case (sfr_addr)
			sctc_pkg::ADDR_CTRL:      rd_mux = ctrl_r;
			sctc_pkg::ADDR_RELOAD_LO: rd_mux = reload_lo_r;
			sctc_pkg::ADDR_RELOAD_HI: rd_mux = reload_hi_r;
			sctc_pkg::ADDR_COUNT_LO:  rd_mux = count_lo_r;
			sctc_pkg::ADDR_COUNT_HI:  rd_mux = count_hi_r;
			default:                  rd_mux = sctc_pkg::BYTE_RESET;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= cap_pin;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r      <= sctc_pkg::CTRL_RESET;
			reload_lo_r <= sctc_pkg::BYTE_RESET;
			reload_hi_r <= sctc_pkg::BYTE_RESET;
			count_lo_r  <= sctc_pkg::BYTE_RESET;
			count_hi_r  <= sctc_pkg::BYTE_RESET;
		end else begin
			ctrl_r      <= ctrl_nxt;
			reload_lo_r <= reload_lo_nxt;
			reload_hi_r <= reload_hi_nxt;
			count_lo_r  <= count_lo_nxt;
			count_hi_r  <= count_hi_nxt;
		end
	end

	// Irq is registered from next flag state so it tracks the flags cycle for cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer_irq_r <= 1'b0;
			sfr_rdata_r <= sctc_pkg::BYTE_RESET;
		end else begin
			timer_irq_r <= ctrl_nxt.high_event_flag |
				(ctrl_nxt.low_event_flag & ctrl_nxt.low_irq_enable); // RQ6
			sfr_rdata_r <= sfr_rd ? rd_mux : sfr_rdata_r;
		end
	end

	assign sfr_rdata = sfr_rdata_r;
	assign timer_irq = timer_irq_r;

	chk_irq_equation: assert property (@(posedge clock) disable iff (!reset_n) // RQ6
		timer_irq == (ctrl_r.high_event_flag | (ctrl_r.low_event_flag & ctrl_r.low_irq_enable)))
		else $error("irq differs from flag combination");

	chk_high_sticky: assert property (@(posedge clock) disable iff (!reset_n) // RQ2
		(ctrl_r.high_event_flag & ~wr_ctrl) |=> ctrl_r.high_event_flag)
		else $error("high flag dropped without a write");

	chk_low_sticky: assert property (@(posedge clock) disable iff (!reset_n) // RQ3
		(ctrl_r.low_event_flag & ~wr_ctrl) |=> ctrl_r.low_event_flag)
		else $error("low flag dropped without a write");

	chk_set_beats_clear: assert property (@(posedge clock) disable iff (!reset_n) // RQ18
		(wr_ctrl & ~sfr_wdata[7] & evt.set_high) |=> ctrl_r.high_event_flag)
		else $error("clear beat a same-cycle set");

	chk_wide_reload: assert property (@(posedge clock) disable iff (!reset_n) // RQ14
		(full_roll & ~lo_cap & ~wr_cl & ~wr_ch) |=>
		(count_lo_r == $past(reload_lo_r)) && (count_hi_r == $past(reload_hi_r)) && ctrl_r.high_event_flag)
		else $error("wide overflow missed reload");

	chk_capture_copy: assert property (@(posedge clock) disable iff (!reset_n) // RQ16
		(cap_event & lo_cap) |=> (reload_lo_r == $past(count_lo_r)))
		else $error("capture did not latch low byte");

	chk_capture_pin: assert property (@(posedge clock) disable iff (!reset_n) // RQ17
		($rose(pin_sync_r) & cap_rise_en & lo_cap & wide) |=> ctrl_r.high_event_flag)
		else $error("rising capture edge did not set high flag");

	chk_wide_low_roll: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
		(wide & ~lo_cap & lo_roll) |=> ctrl_r.low_event_flag)
		else $error("wide low byte roll missed low flag");

	chk_high_cap_ignored: assert property (@(posedge clock) disable iff (!reset_n) // RQ8
		(wide & ~lo_cap & cap_event & ~full_roll & ~ctrl_r.high_event_flag & ~wr_ctrl) |=>
		~ctrl_r.high_event_flag)
		else $error("capture acted in wide timer mode");

	chk_write_now: assert property (@(posedge clock) disable iff (!reset_n) // RQ12
		(wr_rh & ~evt.cap_high) |=> (reload_hi_r == $past(sfr_wdata)))
		else $error("reload write delayed");

	chk_wide_cap_carry: assert property (@(posedge clock) disable iff (!reset_n) // RQ5
		(wide & lo_cap & full_roll) |=> ctrl_r.low_event_flag)
		else $error("wide capture overflow missed low flag");

	chk_split_high_reload: assert property (@(posedge clock) disable iff (!reset_n) // RQ1
		(~wide & ~hi_cap & hi_roll_s & ~wr_ch) |=>
		(count_hi_r == $past(reload_hi_r)) && ctrl_r.high_event_flag)
		else $error("split high overflow missed reload");

	cov_split_high_roll: cover property (@(posedge clock) disable iff (!reset_n) hi_roll_s & ~hi_cap);
	cov_wide_overflow: cover property (@(posedge clock) disable iff (!reset_n) full_roll & ~lo_cap);
	cov_wide_capture:  cover property (@(posedge clock) disable iff (!reset_n) cap_event & wide & lo_cap);
	cov_split_both:    cover property (@(posedge clock) disable iff (!reset_n) evt.cap_low & evt.cap_high & ~wide);
endmodule : sctc_timer

// [test/sctc_cpu_model.sv]
// Purpose: Processor core side of the special function register bus
// Assumes: Design samples its strobes on the rising clock edge
// Notes:   Drives on the falling edge so no change races the sampling edge
module sctc_cpu_model (
	input  wire logic       clock,
	output logic      [7:0] sfr_addr,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic      [7:0] sfr_wdata,
	input  wire logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sfr_addr  = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr    = 1'b0;
		sfr_rd    = 1'b0;
	end
	// Idle address and data are inverted so a stale value can never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(negedge clock);
		sfr_wr    <= 1'b0;
		sfr_addr  <= ~a;
		sfr_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(negedge clock);
		sfr_rd   <= 1'b0;
		sfr_addr <= ~a;
		d = sfr_rdata;
	endtask : rd
endmodule : sctc_cpu_model

// [test/sctc_timer_tb.sv]
// Purpose: Self-checking bench for the split capture timer control
// Assumes: Capture reaches the registers within six cycles of a pin edge
// Notes:   Flags are cleared by writing the control byte, as software would
module sctc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0, reset_n = 1'b0, sfr_wr, sfr_rd, timer_irq;
	logic        low_tick = 1'b0, high_tick = 1'b0, cap_pin = 1'b0, cap_rise_en = 1'b0, cap_fall_en = 1'b0;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, v;
	logic [15:0] r, c;
	int          n_mismatch = 0, samples_checked = 0;
	always #4 clock = ~clock;
	sctc_timer u_sctc_timer (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .low_tick(low_tick),
		.high_tick(high_tick), .cap_pin(cap_pin), .cap_rise_en(cap_rise_en), .cap_fall_en(cap_fall_en),
		.timer_irq(timer_irq));
	sctc_cpu_model u_sctc_cpu_model (.clock(clock), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
	function automatic logic [7:0] ctrl_of(input logic h, input logic l, input logic [5:0] cfg);
		return {h, l, cfg};
	endfunction : ctrl_of
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		u_sctc_cpu_model.rd(a, v);
		check(what, v, exp);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_sctc_cpu_model.wr(a, d);
	endtask : wr
	task automatic ticks(input logic lo, input logic hi);
		@(negedge clock);
		low_tick  = lo;
		high_tick = hi;
		@(negedge clock);
		low_tick  = 1'b0;
		high_tick = 1'b0;
	endtask : ticks
	// Pin edge, then enough cycles for the two-stage synchroniser and the capture
	task automatic pin(input logic lvl);
		@(negedge clock);
		cap_pin = lvl;
		repeat (6) @(negedge clock);
	endtask : pin
	task automatic stop_test;
		$display("Checked %0d values, %0d mismatches", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end
	initial begin
		void'($urandom(94557));
		r = 16'($urandom);
		c = 16'($urandom);
		repeat (20) @(negedge clock);
		reset_n = 1'b1;
		rdchk("ctrl reset", sctc_pkg::ADDR_CTRL, sctc_pkg::CTRL_RESET);
		rdchk("reload low reset", sctc_pkg::ADDR_RELOAD_LO, sctc_pkg::BYTE_RESET);
		$display("Test reset done");
		wr(sctc_pkg::ADDR_RELOAD_LO, r[7:0]);
		rdchk("reload low", sctc_pkg::ADDR_RELOAD_LO, r[7:0]);
		wr(sctc_pkg::ADDR_RELOAD_HI, r[15:8]);
		rdchk("unmapped", 8'hc9, sctc_pkg::BYTE_RESET);
		$display("Test registers done");
		wr(sctc_pkg::ADDR_COUNT_LO, sctc_pkg::BYTE_ALL_ONES);
		wr(sctc_pkg::ADDR_COUNT_HI, sctc_pkg::BYTE_ALL_ONES);
		wr(sctc_pkg::ADDR_CTRL, 8'h03);
		ticks(1'b1, 1'b0);
		check("irq wide", {7'h00, timer_irq}, sctc_pkg::BYTE_ONE);
		rdchk("count low wide", sctc_pkg::ADDR_COUNT_LO, r[7:0]);
		rdchk("count high wide", sctc_pkg::ADDR_COUNT_HI, r[15:8]);
		rdchk("flags wide", sctc_pkg::ADDR_CTRL, ctrl_of(1'b1, 1'b1, 6'h03));
		$display("Test wide overflow done");
		// Software clears both flags by writing zeros to them
		wr(sctc_pkg::ADDR_CTRL, 8'h31);
		check("irq cleared", {7'h00, timer_irq}, sctc_pkg::BYTE_RESET);
		wr(sctc_pkg::ADDR_COUNT_LO, sctc_pkg::BYTE_ALL_ONES);
		ticks(1'b1, 1'b1);
		check("irq low", {7'h00, timer_irq}, sctc_pkg::BYTE_ONE);
		rdchk("flags split", sctc_pkg::ADDR_CTRL, ctrl_of(1'b0, 1'b1, 6'h31));
		rdchk("count low split", sctc_pkg::ADDR_COUNT_LO, r[7:0]);
		rdchk("high half idle", sctc_pkg::ADDR_COUNT_HI, r[15:8]);
		$display("Test split overflow done");
		wr(sctc_pkg::ADDR_COUNT_LO, c[7:0]);
		wr(sctc_pkg::ADDR_COUNT_HI, c[15:8]);
		wr(sctc_pkg::ADDR_CTRL, 8'h04);
		cap_rise_en = 1'b1;
		pin(1'b1);
		rdchk("capture low", sctc_pkg::ADDR_RELOAD_LO, c[7:0]);
		rdchk("capture high", sctc_pkg::ADDR_RELOAD_HI, c[15:8]);
		rdchk("flags capture", sctc_pkg::ADDR_CTRL, ctrl_of(1'b1, 1'b0, 6'h04));
		$display("Test wide capture done");
		wr(sctc_pkg::ADDR_CTRL, 8'h08);
		cap_rise_en = 1'b0;
		cap_fall_en = 1'b1;
		pin(1'b0);
		rdchk("high cap ignored", sctc_pkg::ADDR_CTRL, ctrl_of(1'b0, 1'b0, 6'h08));
		pin(1'b1);
		wr(sctc_pkg::ADDR_CTRL, 8'h1c);
		pin(1'b0);
		rdchk("falling capture", sctc_pkg::ADDR_CTRL, ctrl_of(1'b1, 1'b1, 6'h1c));
		rdchk("reload kept", sctc_pkg::ADDR_RELOAD_LO, c[7:0]);
		$display("Test capture edges done");
		wr(sctc_pkg::ADDR_CTRL, 8'h05);
		wr(sctc_pkg::ADDR_COUNT_LO, sctc_pkg::BYTE_ALL_ONES);
		wr(sctc_pkg::ADDR_COUNT_HI, sctc_pkg::BYTE_ALL_ONES);
		ticks(1'b1, 1'b0);
		rdchk("flags wide carry", sctc_pkg::ADDR_CTRL, ctrl_of(1'b0, 1'b1, 6'h05));
		rdchk("count wraps free", sctc_pkg::ADDR_COUNT_LO, sctc_pkg::BYTE_RESET);
		wr(sctc_pkg::ADDR_CTRL, 8'h12);
		wr(sctc_pkg::ADDR_COUNT_HI, sctc_pkg::BYTE_ALL_ONES);
		ticks(1'b0, 1'b1);
		check("irq high", {7'h00, timer_irq}, sctc_pkg::BYTE_ONE);
		rdchk("flags split high", sctc_pkg::ADDR_CTRL, ctrl_of(1'b1, 1'b0, 6'h12));
		rdchk("count high reload", sctc_pkg::ADDR_COUNT_HI, c[15:8]);
		$display("Test overflow modes done");
		stop_test();
	end
endmodule : sctc_timer_tb
